// ---- verilog/scs_pkg.sv ----
// Package of constants and types for the two-wire control and status block.
package scs_pkg;

	// ****************************************************************
	// Control register layout
	// ****************************************************************
	localparam int              CTL_W       = 8;
	localparam int              BIT_MASTER  = 7;
	localparam int              BIT_TRANSMIT_DIRECTION_FLAG  = 6;
	localparam int              BIT_STA     = 5;
	localparam int              BIT_STO     = 4;
	localparam int              BIT_ACK_REQUEST_FLAG   = 3;
	localparam int              BIT_ARBITRATION_LOST_FLAG = 2;
	localparam int              BIT_ACK     = 1;
	localparam int              BIT_SI      = 0;
	localparam logic [CTL_W-1:0] CTL_RESET  = 8'h00;

	// ****************************************************************
	// Link engine counts
	// ****************************************************************
	localparam logic [3:0]      BIT_FIRST   = 4'h0;
	localparam logic [3:0]      BIT_LAST    = 4'h7;
	localparam logic [3:0]      ACK_SLOT    = 4'h8;
	localparam logic [3:0]      FREE_CYC    = 4'ha;

	// ****************************************************************
	// Types
	// ****************************************************************
	typedef enum logic [2:0] {
		L_IDLE,
		L_START,
		L_STOP,
		L_LOW,
		L_HIGH,
		L_STALL
	} scs_lstate_t;

	typedef enum logic [1:0] {
		K_SEND,
		K_ACK,
		K_NEXT,
		K_END
	} scs_stall_t;

endpackage

// ---- verilog/scs_sync.sv ----
// Two flip-flop synchroniser for levels entering a clock domain.
`timescale 1ns/1ns
module scs_sync #(
	parameter int W = 1
) (
	// Destination clock.
	input  wire logic         clk,
	// Level from the other domain and its synchronised copy.
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_r;

	// The first stage feeds only the second, so a metastable value never fans out.
	always_ff @(posedge clk) begin
		meta_r <= d;
		q      <= meta_r;
	end

endmodule

// ---- verilog/scs_control_status.sv ----
// Control and status register with the byte-level bus engine of a two-wire serial port.
//
// How it works
// - Upper nibble forms a dispatch status code.
// - Bit 7 reads one while bus master.
// - Bit 6 reads one while transmitting.
// - Start and stop bits report conditions since interrupt.
// - Writing start enters master mode, stays set.
// - Stop request ends transfer after next acknowledge.
// - Start plus stop gives stop, then start.
// - Acknowledge bit: drive value, or sampled value.
// - Acknowledge request set after each received byte.
// - Unwritten acknowledge bit yields not-acknowledge.
// - Acknowledge write shows on SDA at once.
// - Refused own address ignored until next start.
// - Lost arbitration sets its flag, master or slave.
// - Clearing event flag clears arbitration-lost flag.
// - Event flag set at own start, end, byte, loss.
// - Event flag set holds SCL low, stalling bus, except after a stop.
// - Busy bus delays start until stop or timeout.
// - Start while master repeats start after acknowledge.
// - Stop request clears itself once stop generated.
`timescale 1ns/1ns
module scs_control_status
	import scs_pkg::*;
(
	// System clock and reset.
	input  wire logic                       clk,
	input  wire logic                       rst_n,
	// Control register port from the core.
	input  wire logic                       regWrEn,
	input  wire logic [scs_pkg::CTL_W-1:0]  regWrData,
	output logic      [scs_pkg::CTL_W-1:0]  regRdData,
	// Byte exchange with the core.
	input  wire logic [7:0]                 txByte,
	output logic      [7:0]                 rxByte,
	// Link clock and open-drain bus pins.
	input  wire logic                       linkClk,
	input  wire logic                       sclIn,
	output logic                            sclOut,
	output logic                            sclOutEn,
	input  wire logic                       sdaIn,
	output logic                            sdaOut,
	output logic                            sdaOutEn
);

	import scs_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic        masterBit_r, txModeBit_r, staBit_r, stoBit_r;
	logic        ackRqBit_r, arbLostBit_r, ackBit_r, siBit_r;
	logic        evSeen_r, resumeTgl_r, evTglSync, evArrive, siClear;
	logic        lRstN, staS, stoS, ackS, resS, sclS, sdaS;
	scs_lstate_t lState_r;
	scs_stall_t  stallKind_r;
	logic [1:0]  ph_r;
	logic [3:0]  bitCnt_r, freeCnt_r;
	logic [7:0]  shift_r;
	logic        lMaster_r, lTx_r, firstByte_r, rw_r, resSeen_r, evTgl_r;
	logic        evStart_r, evStopDet_r, evStopGen_r, evRx_r, evArb_r, evAck_r, evAckV_r;
	logic        sclOe_r, sdaOe_r, prevScl_r, prevSda_r, busBusy_r;
	logic        startDet, stopDet;

	// ****************************************************************
	// Domain crossings
	// ****************************************************************
	scs_sync #(.W(1)) uEvSync (
		.clk (clk),
		.d   (evTgl_r),
		.q   (evTglSync)
	);

	scs_sync #(.W(1)) uRstSync (
		.clk (linkClk),
		.d   (rst_n),
		.q   (lRstN)
	);

	scs_sync #(.W(4)) uCtlSync (
		.clk (linkClk),
		.d   ({staBit_r, stoBit_r, ackBit_r, resumeTgl_r}),
		.q   ({staS, stoS, ackS, resS})
	);

	scs_sync #(.W(2)) uPinSync (
		.clk (linkClk),
		.d   ({sclIn, sdaIn}),
		.q   ({sclS, sdaS})
	);

	// The event fields stay frozen while the engine waits for a resume, so they are read as handshake data.
	assign evArrive = evTglSync != evSeen_r;
	assign siClear  = regWrEn & siBit_r & ~regWrData[BIT_SI];

	// ****************************************************************
	// Control register, system clock domain
	// ****************************************************************

	// Event handshake bookkeeping and the resume toggle sent on each flag clear.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			evSeen_r    <= 1'b0;
			resumeTgl_r <= 1'b0;
		end else begin
			evSeen_r <= evTglSync;
			if (siClear && !evArrive) begin
				resumeTgl_r <= ~resumeTgl_r;
			end
		end
	end

	// Role, direction and received byte follow the engine at each event.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			masterBit_r <= CTL_RESET[BIT_MASTER];
			txModeBit_r <= CTL_RESET[BIT_TRANSMIT_DIRECTION_FLAG];
			rxByte      <= 8'h00;
		end else if (evArrive) begin
			masterBit_r <= lMaster_r;
			txModeBit_r <= lTx_r;
			rxByte      <= shift_r;
		end
	end

	// Start bit: hardware sets it on a start but never clears it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			staBit_r <= CTL_RESET[BIT_STA];
		end else if (evArrive && evStart_r) begin
			staBit_r <= 1'b1;
		end else if (regWrEn) begin
			staBit_r <= regWrData[BIT_STA];
		end
	end

	// Stop bit: cleared when our stop went out, set when another master's stop is seen.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stoBit_r <= CTL_RESET[BIT_STO];
		end else if (evArrive && evStopGen_r) begin
			stoBit_r <= 1'b0;
		end else if (evArrive && evStopDet_r) begin
			stoBit_r <= 1'b1;
		end else if (regWrEn) begin
			stoBit_r <= regWrData[BIT_STO];
		end
	end

	// Sticky flags; a setting event wins over a clear in the same cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ackRqBit_r   <= CTL_RESET[BIT_ACK_REQUEST_FLAG];
			arbLostBit_r <= CTL_RESET[BIT_ARBITRATION_LOST_FLAG];
			siBit_r      <= CTL_RESET[BIT_SI];
		end else begin
			if (evArrive && evRx_r) begin
				ackRqBit_r <= 1'b1;
			end else if (siClear) begin
				ackRqBit_r <= 1'b0;
			end
			if (evArrive && evArb_r) begin
				arbLostBit_r <= 1'b1;
			end else if (siClear) begin
				arbLostBit_r <= 1'b0;
			end
			if (evArrive) begin
				siBit_r <= 1'b1;
			end else if (regWrEn) begin
				siBit_r <= regWrData[BIT_SI];
			end
		end
	end

	// Acknowledge bit: preset to refuse on each received byte, loaded with the sample after a sent byte.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ackBit_r <= CTL_RESET[BIT_ACK];
		end else if (evArrive && evRx_r) begin
			ackBit_r <= 1'b0;
		end else if (evArrive && evAckV_r) begin
			ackBit_r <= evAck_r;
		end else if (regWrEn) begin
			ackBit_r <= regWrData[BIT_ACK];
		end
	end

	// Registered read image; the top nibble doubles as the dispatch code.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regRdData <= CTL_RESET;
		end else begin
			regRdData <= {masterBit_r, txModeBit_r, staBit_r, stoBit_r,
				ackRqBit_r, arbLostBit_r, ackBit_r, siBit_r};
		end
	end

	// ****************************************************************
	// Bus monitor, link clock domain
	// ****************************************************************
	assign startDet = prevScl_r & sclS & prevSda_r & ~sdaS;
	assign stopDet  = prevScl_r & sclS & ~prevSda_r & sdaS;

	// Busy tracking; lines idle high for a while also count as free.
	always_ff @(posedge linkClk) begin
		if (!lRstN) begin
			prevScl_r <= 1'b1;
			prevSda_r <= 1'b1;
			busBusy_r <= 1'b0;
			freeCnt_r <= 4'h0;
		end else begin
			prevScl_r <= sclS;
			prevSda_r <= sdaS;
			if (sclS && sdaS) begin
				if (freeCnt_r != FREE_CYC) begin
					freeCnt_r <= freeCnt_r + 4'h1;
				end
			end else begin
				freeCnt_r <= 4'h0;
			end
			if (startDet) begin
				busBusy_r <= 1'b1;
			end else if (stopDet || freeCnt_r == FREE_CYC) begin
				busBusy_r <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Bit engine, link clock domain
	// ****************************************************************

	// One state machine walks start, bits, acknowledge, stop and the stall between them.
	always_ff @(posedge linkClk) begin
		if (!lRstN) begin
			lState_r    <= L_IDLE;
			stallKind_r <= K_END;
			ph_r        <= 2'h0;
			bitCnt_r    <= BIT_FIRST;
			shift_r     <= 8'h00;
			lMaster_r   <= 1'b0;
			lTx_r       <= 1'b0;
			firstByte_r <= 1'b0;
			rw_r        <= 1'b0;
			resSeen_r   <= 1'b0;
			evTgl_r     <= 1'b0;
			evStart_r   <= 1'b0;
			evStopDet_r <= 1'b0;
			evStopGen_r <= 1'b0;
			evRx_r      <= 1'b0;
			evArb_r     <= 1'b0;
			evAck_r     <= 1'b0;
			evAckV_r    <= 1'b0;
			sclOe_r     <= 1'b0;
			sdaOe_r     <= 1'b0;
		end else begin
			unique case (lState_r)
			L_IDLE: begin
				sclOe_r   <= 1'b0;
				sdaOe_r   <= 1'b0;
				lMaster_r <= 1'b0;
				if (startDet) begin
					lState_r    <= L_LOW;
					ph_r        <= 2'h3;
					bitCnt_r    <= BIT_FIRST;
					firstByte_r <= 1'b1;
					lTx_r       <= 1'b0;
					evStart_r   <= 1'b1;
				end else if (staS && !busBusy_r) begin
					lState_r <= L_START;
					ph_r     <= 2'h0;
				end
			end
			L_START: begin
				unique case (ph_r)
				2'h0: begin
					sdaOe_r <= 1'b0;
					ph_r    <= 2'h1;
				end
				2'h1: begin
					sclOe_r <= 1'b0;
					if (sclS && sdaS) begin
						ph_r <= 2'h2;
					end
				end
				2'h2: begin
					sdaOe_r <= 1'b1;
					ph_r    <= 2'h3;
				end
				2'h3: begin
					sclOe_r     <= 1'b1;
					lMaster_r   <= 1'b1;
					lTx_r       <= 1'b1;
					firstByte_r <= 1'b1;
					evStart_r   <= 1'b1;
					stallKind_r <= K_SEND;
					evTgl_r     <= ~evTgl_r;
					lState_r    <= L_STALL;
				end
				endcase
			end
			L_STOP: begin
				unique case (ph_r)
				2'h0: begin
					sclOe_r <= 1'b1;
					sdaOe_r <= 1'b1;
					ph_r    <= 2'h1;
				end
				2'h1: begin
					sclOe_r <= 1'b0;
					if (sclS) begin
						ph_r <= 2'h2;
					end
				end
				2'h2: begin
					sdaOe_r <= 1'b0;
					ph_r    <= 2'h3;
				end
				2'h3: begin
					lMaster_r   <= 1'b0;
					evStopGen_r <= 1'b1;
					ph_r        <= 2'h0;
					if (staS) begin
						lState_r <= L_START;
					end else begin
						stallKind_r <= K_END;
						evTgl_r     <= ~evTgl_r;
						lState_r    <= L_STALL;
					end
				end
				endcase
			end
			L_STALL: begin
				if (stallKind_r == K_ACK) begin
					sdaOe_r <= ackS;
				end
				if (resS != resSeen_r) begin
					resSeen_r   <= resS;
					evStart_r   <= 1'b0;
					evStopDet_r <= 1'b0;
					evStopGen_r <= 1'b0;
					evRx_r      <= 1'b0;
					evArb_r     <= 1'b0;
					evAckV_r    <= 1'b0;
					ph_r        <= 2'h0;
					shift_r     <= txByte;
					bitCnt_r    <= (stallKind_r == K_ACK) ? ACK_SLOT : BIT_FIRST;
					unique case (stallKind_r)
					K_SEND, K_ACK: lState_r <= L_LOW;
					K_NEXT: begin
						if (lMaster_r && stoS) begin
							lState_r <= L_STOP;
						end else if (lMaster_r && staS) begin
							lState_r <= L_START;
						end else begin
							lState_r <= L_LOW;
						end
					end
					K_END: begin
						sclOe_r  <= 1'b0;
						sdaOe_r  <= 1'b0;
						lState_r <= L_IDLE;
					end
					endcase
				end
			end
			L_LOW: begin
				unique case (ph_r)
				2'h0: begin
					if (bitCnt_r == ACK_SLOT) begin
						sdaOe_r <= ~lTx_r & ackS;
					end else begin
						sdaOe_r <= lTx_r & ~shift_r[7];
					end
					ph_r <= 2'h1;
				end
				2'h1: begin
					sclOe_r <= 1'b0;
					ph_r    <= 2'h2;
				end
				2'h2: begin
					if (sclS) begin
						lState_r <= L_HIGH;
						ph_r     <= 2'h0;
						if (bitCnt_r == ACK_SLOT) begin
							evAck_r  <= ~sdaS;
							evAckV_r <= lTx_r;
						end else begin
							shift_r <= {shift_r[6:0], sdaS};
							if (lTx_r && !sdaOe_r && !sdaS) begin
								evArb_r     <= 1'b1;
								lMaster_r   <= 1'b0;
								sclOe_r     <= 1'b1;
								stallKind_r <= K_END;
								evTgl_r     <= ~evTgl_r;
								lState_r    <= L_STALL;
							end
						end
					end
				end
				2'h3: begin
					if (!sclS) begin
						ph_r <= 2'h0;
					end
				end
				endcase
			end
			L_HIGH: begin
				if (!lMaster_r && stopDet) begin
					evStopDet_r <= 1'b1;
					sclOe_r     <= 1'b0;
					sdaOe_r     <= 1'b0;
					stallKind_r <= K_END;
					evTgl_r     <= ~evTgl_r;
					lState_r    <= L_STALL;
				end else if (!lMaster_r && startDet) begin
					lState_r    <= L_LOW;
					ph_r        <= 2'h3;
					bitCnt_r    <= BIT_FIRST;
					firstByte_r <= 1'b1;
					lTx_r       <= 1'b0;
					evStart_r   <= 1'b1;
				end else if (ph_r == 2'h0) begin
					sclOe_r <= lMaster_r;
					ph_r    <= 2'h1;
				end else if (!sclS) begin
					ph_r <= 2'h0;
					if (bitCnt_r < BIT_LAST) begin
						bitCnt_r <= bitCnt_r + 4'h1;
						lState_r <= L_LOW;
					end else if (bitCnt_r == BIT_LAST) begin
						if (firstByte_r) begin
							rw_r <= shift_r[0];
						end
						bitCnt_r <= ACK_SLOT;
						if (lTx_r) begin
							sdaOe_r  <= 1'b0;
							lState_r <= L_LOW;
						end else begin
							evRx_r      <= 1'b1;
							sclOe_r     <= 1'b1;
							stallKind_r <= K_ACK;
							evTgl_r     <= ~evTgl_r;
							lState_r    <= L_STALL;
						end
					end else begin
						firstByte_r <= 1'b0;
						sdaOe_r     <= 1'b0;
						bitCnt_r    <= BIT_FIRST;
						if (lTx_r) begin
							if (firstByte_r && lMaster_r) begin
								lTx_r <= ~rw_r;
							end
							sclOe_r     <= 1'b1;
							stallKind_r <= K_NEXT;
							evTgl_r     <= ~evTgl_r;
							lState_r    <= L_STALL;
						end else if (!lMaster_r && firstByte_r && !ackS) begin
							sclOe_r  <= 1'b0;
							lState_r <= L_IDLE;
						end else begin
							if (firstByte_r && !lMaster_r) begin
								lTx_r <= rw_r;
							end
							if (lMaster_r && stoS) begin
								lState_r <= L_STOP;
							end else if (lMaster_r && staS) begin
								lState_r <= L_START;
							end else begin
								lState_r <= L_LOW;
							end
						end
					end
				end
			end
			endcase
		end
	end

	// Open-drain pins only ever pull low; the enables carry the bus activity.
	always_ff @(posedge linkClk) begin
		sclOut <= 1'b0;
		sdaOut <= 1'b0;
	end

	assign sclOutEn = sclOe_r;
	assign sdaOutEn = sdaOe_r;

endmodule

// ---- tb/scs_control_status_asserts.sv ----
// Checker of the control register image and the bus pin drive.
`timescale 1ns/1ns
module scs_control_status_asserts
	import scs_pkg::*;
(
	// System side.
	input  wire logic                      clk,
	input  wire logic                      rst_n,
	input  wire logic                      regWrEn,
	input  wire logic [scs_pkg::CTL_W-1:0] regWrData,
	input  wire logic [scs_pkg::CTL_W-1:0] regRdData,
	// Bus pin drive.
	input  wire logic                      sclOutEn,
	input  wire logic                      sdaOutEn
);
	// ********
	// Relations sampled on the system clock.
	// ********
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	property p_rst_clear;
		$rose(rst_n) |-> regRdData == CTL_RESET;
	endproperty
	a_rst_clear: assert property (p_rst_clear) else $error("image not clear after reset");
	property p_sta_set;
		regWrEn && regWrData[BIT_STA] |-> ##2 regRdData[BIT_STA];
	endproperty
	a_sta_set: assert property (p_sta_set) else $error("start bit not stored");
	// Only a write may take the start bit down, two cycles before the image shows it.
	property p_sta_kept;
		$fell(regRdData[BIT_STA]) |-> $past(regWrEn, 2) && !$past(regWrData[BIT_STA], 2);
	endproperty
	a_sta_kept: assert property (p_sta_kept) else $error("start bit cleared by hardware");
	property p_arb_ev;
		regRdData[BIT_ARBITRATION_LOST_FLAG] |-> regRdData[BIT_SI];
	endproperty
	a_arb_ev: assert property (p_arb_ev) else $error("arbitration flag outlived event flag");
	property p_ack_request_flag;
		$rose(regRdData[BIT_ACK_REQUEST_FLAG]) |-> !regRdData[BIT_TRANSMIT_DIRECTION_FLAG] && !regRdData[BIT_ACK] && regRdData[BIT_SI];
	endproperty
	a_ack_request_flag: assert property (p_ack_request_flag) else $error("bad image on received byte");
	property p_stall;
		regRdData[BIT_SI] && regRdData[BIT_MASTER] |-> sclOutEn;
	endproperty
	a_stall: assert property (p_stall) else $error("clock line released while stalled");
	property p_ack_drive;
		regWrEn && regWrData[BIT_ACK] && regWrData[BIT_SI] && regRdData[BIT_ACK_REQUEST_FLAG] |-> ##[2:12] sdaOutEn;
	endproperty
	a_ack_drive: assert property (p_ack_drive) else $error("acknowledge not driven");
	property p_start_ev;
		regWrEn && regWrData[BIT_STA] && !regRdData[BIT_MASTER] && !regRdData[BIT_SI]
			|-> ##[2:400] regRdData[BIT_SI] && regRdData[BIT_MASTER];
	endproperty
	a_start_ev: assert property (p_start_ev) else $error("no master start event");
	property p_sto_clear;
		regRdData[BIT_STO] && regRdData[BIT_MASTER] && !regRdData[BIT_SI] |-> ##[1:1000] !regRdData[BIT_STO];
	endproperty
	a_sto_clear: assert property (p_sto_clear) else $error("stop request never done");
	// A generated stop alone ends mastership with an event soon after.
	property p_sto_end;
		$fell(regRdData[BIT_STO]) && !regRdData[BIT_STA] && !$past(regWrEn, 2)
			|-> ##[0:600] regRdData[BIT_SI] && !regRdData[BIT_MASTER];
	endproperty
	a_sto_end: assert property (p_sto_end) else $error("stop did not end the transfer");
endmodule
bind scs_control_status scs_control_status_asserts u_chk (
	.clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regWrData(regWrData),
	.regRdData(regRdData), .sclOutEn(sclOutEn), .sdaOutEn(sdaOutEn)
);

// ---- tb/scs_bus_slave.sv ----
// Behavioural slave device on the two-wire bus.
`timescale 1ns/1ns
module scs_bus_slave #(
	parameter logic [6:0] ADDR = 7'h2a,
	parameter logic [7:0] RDV  = 8'ha6
) (
	// Resolved lines and pace control.
	input  wire logic       scl,
	input  wire logic       sda,
	input  wire logic       slow,
	// Line pulls and what was seen.
	output logic            sclPull,
	output logic            sdaPull,
	output logic [7:0]      gotByte,
	output logic            lastAck
);
	event       go;
	logic [7:0] sh;
	initial begin
		sclPull = 1'b0;
		sdaPull = 1'b0;
		gotByte = 8'h00;
		lastAck = 1'b0;
	end
	// A start or stop ends any transfer; a start also opens a new one.
	always @(sda) if (scl === 1'b1) begin
		disable xfer;
		sdaPull = 1'b0;
		if (!sda)
			->> go;
	end
	// Address first, then bytes in the direction its lowest bit asks for.
	always begin
		@go;
		begin : xfer
			repeat (8) @(posedge scl) sh = {sh[6:0], sda};
			@(negedge scl);
			if (sh[7:1] == ADDR) begin
				sdaPull = 1'b1;
				@(negedge scl);
				sdaPull = 1'b0;
				// A slow device stretches the clock after its address.
				if (slow) begin
					sclPull = 1'b1;
					#300 sclPull = 1'b0;
				end
				forever if (sh[0]) begin
					for (int i = 7; i >= 0; i--) begin
						sdaPull = ~RDV[i];
						@(negedge scl);
					end
					sdaPull = 1'b0;
					@(posedge scl) lastAck = ~sda;
					@(negedge scl);
				end else begin
					repeat (8) @(posedge scl) gotByte = {gotByte[6:0], sda};
					@(negedge scl);
					sdaPull = 1'b1;
					@(negedge scl);
					sdaPull = 1'b0;
				end
			end
		end
	end
endmodule

// ---- tb/scs_control_status_tb.sv ----
// Self-checking bench of the control register and its bus engine.
`timescale 1ns/1ns
module scs_control_status_tb;
	import scs_pkg::*;
	localparam logic [6:0] SLV = 7'h2a;
	localparam logic [7:0] RDV = 8'ha6;
	logic       clk = 1'b0;
	logic       linkClk = 1'b0;
	logic       rst_n = 1'b0;
	logic       regWrEn = 1'b0;
	logic       slow = 1'b0;
	logic       sdaJam = 1'b0;
	logic [7:0] regWrData = 8'h00;
	logic [7:0] txByte = 8'h00;
	logic [7:0] regRdData, rxByte, gotByte;
	logic       sclOut, sclOutEn, sdaOut, sdaOutEn, sclPull, sdaPull, lastAck;
	logic [1:0] cond = 2'b00;
	int         error_cnt = 0;
	int         tests_run = 0;
	wire        sclW = ~(sclOutEn | sclPull);
	// The jam stands for a second master that holds the data line low.
	wire        sdaW = ~(sdaOutEn | sdaPull | sdaJam);
	// ********
	// Clocks, lines and instances.
	// ********
	always #5 clk = ~clk;
	always #6 linkClk = ~linkClk;
	// Keeps the last two bus conditions, a one standing for a stop.
	always @(sdaW) if (sclW === 1'b1)
		cond <= {cond[0], sdaW};
	scs_control_status dut (.clk(clk), .rst_n(rst_n), .regWrEn(regWrEn), .regWrData(regWrData),
		.regRdData(regRdData), .txByte(txByte), .rxByte(rxByte), .linkClk(linkClk), .sclIn(sclW),
		.sclOut(sclOut), .sclOutEn(sclOutEn), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOutEn(sdaOutEn));
	scs_bus_slave #(.ADDR(SLV), .RDV(RDV)) u_slv (.scl(sclW), .sda(sdaW), .slow(slow),
		.sclPull(sclPull), .sdaPull(sdaPull), .gotByte(gotByte), .lastAck(lastAck));
	// ********
	// Shared tasks.
	// ********
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One register write; returns once the image can show it.
	task automatic wr(input logic [7:0] d, input logic [7:0] t);
		@(posedge clk);
		regWrEn <= 1'b1;
		regWrData <= d;
		txByte <= t;
		@(posedge clk);
		regWrEn <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// Bounded wait for the event flag.
	task automatic wev();
		int n = 0;
		while (regRdData[BIT_SI] !== 1'b1 && n < 3000) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk({7'h00, regRdData[BIT_SI]}, 8'h01);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ********
	// Scenarios.
	// ********
	task automatic t_reset();
		chk(regRdData, CTL_RESET);
		chk({4'h0, sclOut, sdaOut, sclOutEn, sdaOutEn}, 8'h00);
		wr(8'hcc, 8'h00);
		chk(regRdData, 8'h00);
		$display("test reset done");
	endtask
	// Write of address and one data byte, then a stop.
	task automatic t_write();
		wr(8'h20, 8'h00);
		wev();
		chk(regRdData & 8'hf1, 8'he1);
		wr(8'h00, {SLV, 1'b0});
		wev();
		chk(regRdData & 8'hf3, 8'hc3);
		wr(8'h00, 8'h5a);
		wev();
		chk(regRdData & 8'hf3, 8'hc3);
		chk(gotByte, 8'h5a);
		wr(8'h10, 8'h00);
		wev();
		chk(regRdData & 8'h98, 8'h00);
		wr(8'h00, 8'h00);
		chk({6'h00, sclW, sdaW}, 8'h03);
		$display("test write done");
	endtask
	// Read from a slow device, acknowledge once, then refuse by default.
	task automatic t_read();
		slow <= 1'b1;
		wr(8'h20, 8'h00);
		wev();
		wr(8'h00, {SLV, 1'b1});
		wev();
		chk(regRdData & 8'hc3, 8'h83);
		wr(8'h00, 8'h00);
		wev();
		chk(regRdData & 8'hcb, 8'h89);
		chk(rxByte, RDV);
		wr(8'h03, 8'h00);
		repeat (6) @(posedge clk);
		chk({6'h00, sclOutEn, sdaOutEn}, 8'h03);
		wr(8'h02, 8'h00);
		wev();
		chk(regRdData & 8'h0b, 8'h09);
		chk({7'h00, lastAck}, 8'h01);
		wr(8'h10, 8'h00);
		wev();
		chk({7'h00, lastAck}, 8'h00);
		wr(8'h00, 8'h00);
		slow <= 1'b0;
		$display("test read done");
	endtask
	// Start and stop together give a stop and then a new start.
	task automatic t_stasto();
		wr(8'h20, 8'h00);
		wev();
		wr(8'h00, {SLV, 1'b0});
		wev();
		wr(8'h30, 8'h00);
		wev();
		chk(regRdData & 8'hb1, 8'ha1);
		chk({6'h00, cond}, 8'h02);
		wr(8'h10, {SLV, 1'b0});
		wev();
		chk(regRdData & 8'h93, 8'h93);
		wr(8'h10, 8'h00);
		wev();
		chk(regRdData & 8'h90, 8'h00);
		wr(8'h00, 8'h00);
		$display("test start stop done");
	endtask
	// Repeated start with no stop between, then a jammed data line costs the arbitration.
	task automatic t_arb();
		wr(8'h20, 8'h00);
		wev();
		wr(8'h00, {SLV, 1'b0});
		wev();
		wr(8'h20, 8'h00);
		wev();
		chk(regRdData & 8'hb1, 8'ha1);
		chk({6'h00, cond}, 8'h00);
		// The jam goes on and off only while the engine holds the clock line low.
		sdaJam <= 1'b1;
		wr(8'h00, 8'hff);
		wev();
		chk(regRdData & 8'h85, 8'h05);
		sdaJam <= 1'b0;
		wr(8'h00, 8'h00);
		chk(regRdData & 8'h05, 8'h00);
		$display("test arbitration done");
	endtask
	// ********
	// Main sequence and watchdog.
	// ********
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_reset();
		t_write();
		t_read();
		t_stasto();
		t_arb();
		stop_test();
	end
	initial begin
		#400000;
		error_cnt++;
		stop_test();
	end
endmodule
